// ===== design/ctmtc_top.sv
`timescale 1ns/1ps
// Function
// - The capacitance start-pin field picks which general port starts a pulse-triggered capacitance run.
// - The capacitance source field selects software, continuous, timer or pulse starting.
// - The capacitance cycle lasts the programmed number of low-frequency oscillator periods, with zero acting as one.
// - The temperature cycle lasts 140 us with its bit clear and 280 us with it set.
// - The temperature start-pin field picks which general port starts a pulse-triggered temperature run.
// - Temperature source 0 means command only, 1 means after capacitance runs and 3 means the start-pin edge; 2 is not for use.
// - Temperature averaging code 0,1,2,3 takes 1,4,8,16 results.
// - A temperature run follows every N-th capacitance run, with N of zero acting as one.
// - The dummy count sets how many throwaway temperature conversions come first.
// - With mirroring set, general port 2 repeats the active-low interrupt beside its own pin.
// - Two select bits steer pulse output 0 to port 0 or 2 and pulse output 1 to port 1 or 3.
module ctmtc_top (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        olf_tick,
   input  wire logic        irq_level,
   input  wire logic [1:0]  pulse_code,
   input  wire logic [1:0]  pulse_code_en,
   input  wire logic [3:0]  general_port_in,
   output logic [3:0]       general_port_out,
   output logic [3:0]       general_port_oe,
   output logic             interrupt_out_n,
   output logic             cap_start_q,
   output logic             temp_start_q,
   output logic             temp_dummy_q
);
   import ctmtc_pkg::*;

   typedef enum logic [1:0] {
      T_IDLE = 2'b00,
      T_LOAD = 2'b01,
      T_CONV = 2'b11
   } ctmtc_tstate_t;

   // ---------------------------------------------
   // Registers and fields
   // ---------------------------------------------
   logic [23:0]         presc_reg_q, fake_reg_q, cfg7_q, irqp_q;
   logic [15:0]         timer_q;
   logic                ack_q;
   logic [3:0]          idx;
   logic                cmd_cap, cmd_temp, wr_go;
   ctmtc_src_t          cap_src;
   logic [1:0]          temp_src, avg_code, dummy_n;
   logic [CAP_CYC_W-1:0] cap_len;
   logic [PRESC_W-1:0]  presc, presc_cnt_q;
   logic                presc_hit;
   logic                cap_busy, cap_done, tmr_busy, tmr_done;
   logic                tmp_busy, tmp_done, tmp_load;
   logic                cap_rise, temp_rise, cap_go, temp_go;
   logic [5:0]          conv_total, conv_idx_q;
   logic [TEMP_CNT_W-1:0] temp_len;
   ctmtc_tstate_t       tstate_q;

   assign idx      = avs_address[5:2];
   assign wr_go    = avs_write & ack_q;
   assign cmd_cap  = wr_go & (idx == IDX_COMMAND) & avs_byteenable[0] & avs_writedata[CMD_CAP_BIT];
   assign cmd_temp = wr_go & (idx == IDX_COMMAND) & avs_byteenable[0] & avs_writedata[CMD_TEMP_BIT];
   assign cap_src  = ctmtc_src_t'(cfg7_q[CAP_SRC_LSB +: 2]);
   assign temp_src = cfg7_q[TEMP_SRC_LSB +: 2];
   assign cap_len  = cfg7_q[CAP_CYC_LSB +: CAP_CYC_W];
   assign avg_code = presc_reg_q[AVG_LSB +: 2];
   assign presc    = presc_reg_q[PRESC_W-1:0];
   assign dummy_n  = fake_reg_q[DUMMY_LSB +: 2];

   // Byte-lane merge for 24-bit registers
   function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [23:0] r;
      r = old;
      for (int i = 0; i < 3; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : merge24

   // ---------------------------------------------
   // Avalon slave: one wait cycle, then answer
   // ---------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ack_q           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (clk_en) begin
         if ((avs_read | avs_write) & ~ack_q) begin
            ack_q           <= 1'b1;
            avs_waitrequest <= 1'b0;
            case (idx)
               IDX_STATUS:        avs_readdata <= {18'h0, conv_idx_q, 5'h00, temp_dummy_q, tmp_busy | (tstate_q != T_IDLE), cap_busy};
               IDX_TIMER:         avs_readdata <= {16'h0000, timer_q};
               IDX_TEMP_PRESCALE: avs_readdata <= {8'h00, presc_reg_q};
               IDX_TEMP_FAKE:     avs_readdata <= {8'h00, fake_reg_q};
               IDX_CFG_SEVEN:     avs_readdata <= {8'h00, cfg7_q};
               IDX_IRQ_PULSE:     avs_readdata <= {8'h00, irqp_q};
               default:           avs_readdata <= 32'h0000_0000;
            endcase
         end else begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // Configuration register writes
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         presc_reg_q <= RST_TEMP_PRESCALE;
         fake_reg_q  <= RST_TEMP_FAKE;
         cfg7_q      <= RST_CFG_SEVEN;
         irqp_q      <= RST_IRQ_PULSE;
         timer_q     <= RST_TIMER;
      end else if (clk_en && wr_go) begin
         case (idx)
            IDX_TEMP_PRESCALE: presc_reg_q <= merge24(presc_reg_q, avs_writedata, avs_byteenable);
            IDX_TEMP_FAKE:     fake_reg_q  <= merge24(fake_reg_q, avs_writedata, avs_byteenable);
            IDX_CFG_SEVEN:     cfg7_q      <= merge24(cfg7_q, avs_writedata, avs_byteenable);
            IDX_IRQ_PULSE:     irqp_q      <= merge24(irqp_q, avs_writedata, avs_byteenable);
            IDX_TIMER: begin
               if (avs_byteenable[0]) timer_q[7:0]  <= avs_writedata[7:0];
               if (avs_byteenable[1]) timer_q[15:8] <= avs_writedata[15:8];
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------
   // Capacitance triggering
   // ---------------------------------------------
   // start pin choice
   ctmtc_pin_edge u_cap_pin (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .pins    (general_port_in),
      .sel     (cfg7_q[CAP_PIN_LSB +: 2]),
      .rise_q  (cap_rise)
   );

   // Internal trigger timer in oscillator periods
   ctmtc_cycle_timer #(.W(16)) u_trig_timer (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .load    ((cap_src == SRC_TIMER) & ~tmr_busy & ~tmr_done),
      .length  (timer_q),
      .tick    (olf_tick),
      .busy_q  (tmr_busy),
      .done_q  (tmr_done)
   );

   always_comb begin
      case (cap_src)
         SRC_CONTINUOUS: cap_go = cmd_cap | ~cap_done;
         SRC_TIMER:      cap_go = cmd_cap | tmr_done;
         SRC_PULSE:      cap_go = cmd_cap | cap_rise;
         default:        cap_go = cmd_cap;
      endcase
   end

   // Start pulse, refused while a run is active
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cap_start_q <= 1'b0;
      end else if (clk_en) begin
         cap_start_q <= cap_go & ~cap_busy & ~cap_start_q;
      end
   end

   ctmtc_cycle_timer #(.W(CAP_CYC_W)) u_cap_cycle (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .load    (cap_start_q),
      .length  (cap_len),
      .tick    (olf_tick),
      .busy_q  (cap_busy),
      .done_q  (cap_done)
   );

   // ---------------------------------------------
   // Temperature triggering
   // ---------------------------------------------
   // start pin choice
   ctmtc_pin_edge u_temp_pin (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .pins    (general_port_in),
      .sel     (cfg7_q[TEMP_PIN_LSB +: 2]),
      .rise_q  (temp_rise)
   );

   assign presc_hit = (presc_cnt_q + PRESC_W'(1)) >= ((presc == '0) ? PRESC_W'(1) : presc);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         presc_cnt_q <= '0;
      end else if (clk_en && cap_done && temp_src == TSRC_CAP) begin
         presc_cnt_q <= presc_hit ? '0 : presc_cnt_q + PRESC_W'(1);
      end
   end

   // command, capacitance runs (source 1) or the start pin (source 3) start it
   always_comb begin
      case (temp_src)
         TSRC_CAP:   temp_go = cmd_temp | (cap_done & presc_hit);
         2'h3:       temp_go = cmd_temp | temp_rise;
         default:    temp_go = cmd_temp;
      endcase
   end

   always_comb begin
      case (avg_code)
         2'h1:    conv_total = 6'(dummy_n) + 6'd4;
         2'h2:    conv_total = 6'(dummy_n) + 6'd8;
         2'h3:    conv_total = 6'(dummy_n) + 6'd16;
         default: conv_total = 6'(dummy_n) + 6'd1;
      endcase
   end

   // Sequence of conversions
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tstate_q     <= T_IDLE;
         conv_idx_q   <= '0;
         temp_start_q <= 1'b0;
         temp_dummy_q <= 1'b0;
      end else if (clk_en) begin
         temp_start_q <= 1'b0;
         case (tstate_q)
            T_IDLE: begin
               conv_idx_q <= '0;
               if (temp_go) begin
                  tstate_q <= T_LOAD;
               end
            end
            T_LOAD: begin
               temp_start_q <= 1'b1;
               temp_dummy_q <= conv_idx_q < 6'(dummy_n);
               tstate_q     <= T_CONV;
            end
            T_CONV: begin
               if (tmp_done) begin
                  conv_idx_q <= conv_idx_q + 6'd1;
                  if (conv_idx_q + 6'd1 >= conv_total) begin
                     tstate_q     <= T_IDLE;
                     temp_dummy_q <= 1'b0;
                  end else begin
                     tstate_q <= T_LOAD;
                  end
               end
            end
            default: tstate_q <= T_IDLE;
         endcase
      end
   end

   assign tmp_load = temp_start_q;
   assign temp_len = cfg7_q[TEMP_CYC_BIT] ? TEMP_CNT_W'(TEMP_CYC_LONG) : TEMP_CNT_W'(TEMP_CYC_SHORT);

   ctmtc_cycle_timer #(.W(TEMP_CNT_W)) u_temp_cycle (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .load    (tmp_load),
      .length  (temp_len),
      .tick    (1'b1),
      .busy_q  (tmp_busy),
      .done_q  (tmp_done)
   );

   // ---------------------------------------------
   // Port routing
   // ---------------------------------------------
   // interrupt mirror and pulse steering
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         interrupt_out_n  <= 1'b1;
         general_port_out <= 4'h0;
         general_port_oe  <= 4'h0;
      end else if (clk_en) begin
         interrupt_out_n  <= ~irq_level;
         general_port_out <= 4'h0;
         general_port_oe  <= 4'h0;
         if (pulse_code_en[0]) begin
            general_port_out[irqp_q[PULSE0_SEL_BIT] ? 0 : 2] <= pulse_code[0];
            general_port_oe[irqp_q[PULSE0_SEL_BIT] ? 0 : 2]  <= 1'b1;
         end
         if (pulse_code_en[1]) begin
            general_port_out[irqp_q[PULSE1_SEL_BIT] ? 1 : 3] <= pulse_code[1];
            general_port_oe[irqp_q[PULSE1_SEL_BIT] ? 1 : 3]  <= 1'b1;
         end
         if (irqp_q[IRQ_MIRROR_BIT]) begin
            general_port_out[2] <= ~irq_level;  // Mirror wins over pulse
            general_port_oe[2]  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   logic [TEMP_CNT_W:0] tlen_cnt_q;
   logic [CAP_CYC_W:0]  clen_cnt_q;
   logic [CAP_CYC_W-1:0] clen_ref_q;
   logic                tcyc_long_q;

   // Helper counters of cycle lengths, settings latched at load against mid-run rewrites
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tlen_cnt_q  <= '0;
         clen_cnt_q  <= '0;
         clen_ref_q  <= '0;
         tcyc_long_q <= 1'b0;
      end else if (clk_en) begin
         tlen_cnt_q  <= tmp_load ? '0 : (tmp_busy ? tlen_cnt_q + 1'b1 : tlen_cnt_q);
         clen_cnt_q  <= cap_start_q ? '0 : ((cap_busy & olf_tick) ? clen_cnt_q + 1'b1 : clen_cnt_q);
         clen_ref_q  <= cap_start_q ? cap_len : clen_ref_q;
         tcyc_long_q <= tmp_load ? cfg7_q[TEMP_CYC_BIT] : tcyc_long_q;
      end
   end

   property p_sw_only;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      (cap_src == SRC_SOFTWARE) && !cmd_cap |=> !cap_start_q;
   endproperty
   a_sw_only: assert property (p_sw_only) else $error("capacitance started without command");

   property p_cont;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      (cap_src == SRC_CONTINUOUS) && !cap_busy && !cap_start_q && !cap_done |=> cap_start_q;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous mode did not restart");

   property p_pin;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      (cap_src == SRC_PULSE) && cap_rise && !cap_busy && !cap_start_q |=> cap_start_q ##1 cap_busy;
   endproperty
   a_pin: assert property (p_pin) else $error("pin edge did not start capacitance");

   property p_cap_len;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      $rose(cap_done) |-> clen_cnt_q == ((clen_ref_q == '0) ? 1 : clen_ref_q);
   endproperty
   a_cap_len: assert property (p_cap_len) else $error("capacitance cycle length wrong");

   property p_temp_len;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      $rose(tmp_done) |-> tlen_cnt_q == (tcyc_long_q ? TEMP_CYC_LONG : TEMP_CYC_SHORT);
   endproperty
   a_temp_len: assert property (p_temp_len) else $error("temperature cycle length wrong");

   property p_presc;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      cap_done && (temp_src == TSRC_CAP) && presc_hit && (tstate_q == T_IDLE) |=> tstate_q == T_LOAD ##1 temp_start_q;
   endproperty
   a_presc: assert property (p_presc) else $error("temperature run missed after prescale");

   property p_no_timer_temp;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      (temp_src == 2'h2) && !cmd_temp && (tstate_q == T_IDLE) |=> tstate_q == T_IDLE;
   endproperty
   a_no_timer_temp: assert property (p_no_timer_temp) else $error("temperature started by reserved source");

   property p_conv_count;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      (tstate_q == T_CONV) && tmp_done && (conv_idx_q + 6'd1 < conv_total) |=> tstate_q == T_LOAD;
   endproperty
   a_conv_count: assert property (p_conv_count) else $error("sequence ended before all conversions");

   property p_dummy;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      temp_start_q |-> temp_dummy_q == (conv_idx_q < 6'(dummy_n));
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy flag wrong");

   property p_mirror;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      irqp_q[IRQ_MIRROR_BIT] |=> general_port_oe[2] && (general_port_out[2] == interrupt_out_n);
   endproperty
   a_mirror: assert property (p_mirror) else $error("interrupt not mirrored on port 2");

   property p_pulse0;
      @(posedge sys_clk) disable iff (srst || !clk_en)
      pulse_code_en[0] && irqp_q[PULSE0_SEL_BIT] |=> general_port_oe[0] && general_port_out[0] == $past(pulse_code[0]);
   endproperty
   a_pulse0: assert property (p_pulse0) else $error("pulse output 0 not on port 0");
endmodule : ctmtc_top

// ===== design/ctmtc_pkg.sv
package ctmtc_pkg;
   // ---------------------------------------------
   // Clock and timing
   // ---------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 100;
   localparam int TEMP_CYC_SHORT_NS = 140000;  // 140 us
   localparam int TEMP_CYC_LONG_NS  = 280000;  // 280 us
   localparam int TEMP_CYC_SHORT    = (TEMP_CYC_SHORT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int TEMP_CYC_LONG     = (TEMP_CYC_LONG_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int TEMP_CNT_W        = 12;
   localparam int OLF_PERIOD_NS     = 20000;   // 20 us at 50 kHz

   // ---------------------------------------------
   // Register indices (byte address = 4 * index)
   // ---------------------------------------------
   localparam logic [3:0] IDX_COMMAND = 4'h0;
   localparam logic [3:0] IDX_STATUS  = 4'h1;
   localparam logic [3:0] IDX_TIMER   = 4'h2;
   localparam logic [3:0] IDX_TEMP_PRESCALE = 4'h5;
   localparam logic [3:0] IDX_TEMP_FAKE     = 4'h6;
   localparam logic [3:0] IDX_CFG_SEVEN     = 4'h7;
   localparam logic [3:0] IDX_IRQ_PULSE     = 4'h8;

   // ---------------------------------------------
   // Reset values
   // ---------------------------------------------
   localparam logic [23:0] RST_TEMP_PRESCALE = 24'h000000;
   localparam logic [23:0] RST_TEMP_FAKE     = 24'h000040;
   localparam logic [23:0] RST_CFG_SEVEN     = 24'h1f0000;
   localparam logic [23:0] RST_IRQ_PULSE     = 24'h000000;
   localparam logic [15:0] RST_TIMER         = 16'h0064;

   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int CAP_PIN_LSB   = 20;  // 2 bits, config word seven
   localparam int CAP_SRC_LSB   = 18;  // 2 bits
   localparam int CAP_CYC_LSB   = 8;   // 10 bits
   localparam int CAP_CYC_W     = 10;
   localparam int TEMP_CYC_BIT  = 7;
   localparam int TEMP_PIN_LSB  = 5;   // 2 bits
   localparam int TEMP_SRC_LSB  = 3;   // 2 bits
   localparam int AVG_LSB       = 22;  // 2 bits, prescale register
   localparam int PRESC_W       = 22;  // bits 21:0
   localparam int DUMMY_LSB     = 6;   // 2 bits, fake register
   localparam int IRQ_MIRROR_BIT = 6;  // interrupt/pulse register
   localparam int PULSE0_SEL_BIT = 5;
   localparam int PULSE1_SEL_BIT = 4;
   localparam int CMD_CAP_BIT   = 0;
   localparam int CMD_TEMP_BIT  = 1;

   // ---------------------------------------------
   // Trigger source codes
   // ---------------------------------------------
   typedef enum logic [1:0] {
      SRC_SOFTWARE = 2'h0,
      SRC_CONTINUOUS = 2'h1,
      SRC_TIMER    = 2'h2,
      SRC_PULSE    = 2'h3
   } ctmtc_src_t;

   localparam logic [1:0] TSRC_CAP = 2'h1;  // temperature after capacitance
endpackage : ctmtc_pkg

// ===== design/ctmtc_pin_edge.sv
`timescale 1ns/1ps
module ctmtc_pin_edge (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       clk_en,
   input  wire logic [3:0] pins,
   input  wire logic [1:0] sel,
   output logic            rise_q
);
   logic [3:0] prev_q;

   // Rising edge on the chosen port; all ports tracked so reset or a new choice gives no false edge
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prev_q <= pins;
         rise_q <= 1'b0;
      end else if (clk_en) begin
         prev_q <= pins;
         rise_q <= pins[sel] & ~prev_q[sel];
      end
   end
endmodule : ctmtc_pin_edge

// ===== design/ctmtc_cycle_timer.sv
`timescale 1ns/1ps
module ctmtc_cycle_timer #(
   parameter int W = 16
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         clk_en,
   input  wire logic         load,
   input  wire logic [W-1:0] length,
   input  wire logic         tick,
   output logic              busy_q,
   output logic              done_q
);
   logic [W-1:0] cnt_q;

   // Count ticks down, zero length counts as one
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (clk_en) begin
         done_q <= 1'b0;
         if (load) begin
            cnt_q  <= (length == '0) ? W'(1) : length;
            busy_q <= 1'b1;
         end else if (busy_q && tick) begin
            if (cnt_q == W'(1)) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - W'(1);
            end
         end
      end
   end
endmodule : ctmtc_cycle_timer

// ===== testbench/cap_temp_measure_trigger_config_test.sv
`timescale 1ns/1ps
`define CHK(n,e,s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %0h got %0h", n, e, s); end end
module cap_temp_measure_trigger_config_test;
   import ctmtc_pkg::*;
   logic        sys_clk, srst, avs_read, avs_write, olf_tick, irq_level, wiggle;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, rnd;
   logic        avs_waitrequest, interrupt_out_n, cap_start_q, temp_start_q, temp_dummy_q;
   logic [1:0]  pulse_code, pulse_code_en;
   logic [3:0]  general_port_in, general_port_out, general_port_oe, k;
   logic [7:0]  pe;
   int          mismatches, comparisons, caps, temps, dums, gap, nexp, tick_cnt;

   ctmtc_top dut (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .olf_tick(olf_tick),
      .irq_level(irq_level), .pulse_code(pulse_code), .pulse_code_en(pulse_code_en),
      .general_port_in(general_port_in), .general_port_out(general_port_out),
      .general_port_oe(general_port_oe), .interrupt_out_n(interrupt_out_n),
      .cap_start_q(cap_start_q), .temp_start_q(temp_start_q), .temp_dummy_q(temp_dummy_q));

   // Clock source
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Oscillator tick every fifth cycle, random pins when enabled
   always @(posedge sys_clk) begin
      tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
      olf_tick <= (tick_cnt == 4);
      if (wiggle) begin
         rnd <= lfsr(rnd);
         general_port_in <= rnd[3:0];
      end
   end

   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // Expected port drive {out & oe, oe} from mirror, pulse0, pulse1 selects
   function automatic logic [7:0] pexp(logic [2:0] c, logic [1:0] pc, logic [1:0] en, logic irq);
      logic [3:0] o, e;
      o = 4'h0;
      e = 4'h0;
      e[c[1] ? 0 : 2] = en[0];
      o[c[1] ? 0 : 2] = pc[0];
      e[c[0] ? 1 : 3] = en[1];
      o[c[0] ? 1 : 3] = pc[1];
      if (c[2]) begin
         e[2] = 1'b1;
         o[2] = ~irq;
      end
      return {o & e, e};
   endfunction : pexp

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address   <= {idx, 2'b00};
      avs_writedata <= wd;
      avs_read      <= ~wr;
      avs_write     <= wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
         close_out();
      end
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // Count start pulses over n cycles and the gap between the first two temperature starts
   task automatic run(input int n);
      int first;
      first = -1;
      caps = 0;
      temps = 0;
      dums = 0;
      gap = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         if (cap_start_q === 1'b1) caps++;
         if (temp_start_q === 1'b1) begin
            temps++;
            if (temp_dummy_q === 1'b1) dums++;
            if (first < 0) first = i;
            else if (gap == 0) gap = i - first;
         end
      end
   endtask : run

   task automatic close_out;
      if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   // Watchdog, well beyond the roughly 70000 cycles of the tests
   initial begin
      #(90000 * 100);
      mismatches++;
      close_out();
   end

   // Main sequence
   initial begin
      {avs_read, avs_write, irq_level, olf_tick, wiggle} = 5'h0;
      {avs_address, avs_writedata, pulse_code, pulse_code_en, general_port_in} = '0;
      rnd = 32'h66e2;
      tick_cnt = 0;
      mismatches = 0;
      comparisons = 0;
      srst = 1'b1;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      bus(0, 4'h7, 0);
      `CHK("cfg7 reset", {8'h0, RST_CFG_SEVEN}, rd)
      for (k = 4'h5; k <= 4'h9; k++) begin
         rnd = lfsr(rnd);
         bus(1, k, rnd);
         bus(0, k, 0);
         `CHK("readback", (k == 4'h9) ? 32'h0 : {8'h0, rnd[23:0]}, rd)
      end
      bus(1, 4'h7, 32'h041300);
      bus(0, 4'h7, 0);
      `CHK("cfg7 start", 32'h041300, rd)
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         bus(1, 4'h8, (i == 0) ? 32'h800030 : rnd & 32'h70);
         {irq_level, pulse_code, pulse_code_en} <= rnd[12:8];
         repeat (4) @(posedge sys_clk);
         pe = pexp(((i == 0) ? 3'h3 : rnd[6:4]), rnd[11:10], rnd[9:8], rnd[12]);
         `CHK("port oe", pe[3:0], general_port_oe)
         `CHK("port out", pe[7:4], general_port_out & general_port_oe)
         `CHK("irq pin", ~rnd[12], interrupt_out_n)
      end
      // every source code with pins wiggling and a short timer
      bus(1, 4'h2, 32'h2);
      wiggle <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         bus(1, 4'h7, (s << 18) | (1 << 8));
         // Skip a start the old source may launch at the write edge
         repeat (2) @(posedge sys_clk);
         run(300);
         `CHK("caps seen", (s != 0), (caps > 0))
      end
      // command only, pins still toggling; let a pulse-mode run finish first
      bus(1, 4'h7, 32'h100);
      repeat (20) @(posedge sys_clk);
      bus(1, 4'h0, 32'h1);
      run(40);
      `CHK("cmd start", 1, caps)
      wiggle <= 1'b0;
      @(posedge sys_clk);
      // only the selected pin starts a pulse run
      for (int s = 0; s < 4; s++) begin
         general_port_in <= 4'h0;
         bus(1, 4'h7, (s << 20) | (3 << 18) | (1 << 8));
         general_port_in <= 4'h1 << ((s + 1) % 4);
         run(30);
         `CHK("other pin", 0, caps)
         general_port_in <= general_port_in | (4'h1 << s);
         run(30);
         `CHK("own pin", 1, caps)
      end
      // averaging counts with dummies and spacing; sequencer adds three clocks per conversion
      for (int a = 0; a < 4; a++) begin
         nexp = (a == 0) ? 1 : (4 << (a - 1));
         bus(1, 4'h7, (a == 1) ? 32'h80 : 32'h0);
         bus(1, 4'h6, a << 6);
         bus(1, 4'h5, a << 22);
         bus(1, 4'h0, 32'h2);
         run((a + nexp + 1) * ((a == 1) ? 2800 : 1400));
         `CHK("temp runs", a + nexp, temps)
         `CHK("dummies", a, dums)
         `CHK("temp gap", (a == 0) ? 0 : ((a == 1) ? TEMP_CYC_LONG + 3 : TEMP_CYC_SHORT + 3), gap)
      end
      // temperature after every N-th capacitance run, zero as one
      bus(1, 4'h7, 32'h108);
      bus(1, 4'h6, 32'h0);
      for (int p = 0; p < 3; p++) begin
         bus(1, 4'h5, (p == 0) ? 32'h0 : 32'h2);
         bus(1, 4'h0, 32'h1);
         run(1450);
         `CHK("temp per cap", (p != 1), temps)
      end
      close_out();
   end
endmodule : cap_temp_measure_trigger_config_test
